// >>> sxd_defines.svh
/*
 * Constants of the six-channel transfer engine: register indexes, control
 * field positions, counter field masks, reset values and timing counts.
 * Assumes inclusion by bare name from the package; the design modules use its macros without including it.
 */
`ifndef SXD_DEFINES_SVH
`define SXD_DEFINES_SVH

/*****************************************************************
 * sizes
 *****************************************************************/
`define SXD_NUM_CH 6
`define SXD_W 24
`define SXD_NUM_OFS 4
`define SXD_NUM_TRIG 8

/*****************************************************************
 * register word indexes on the register port
 *****************************************************************/
`define SXD_IDX_CH_LAST 5'h17
`define SXD_IDX_OFS_BASE 5'h18
`define SXD_IDX_OFS_LAST 5'h1B
`define SXD_IDX_STATUS 5'h1C
`define SXD_SEL_SRC 2'h0
`define SXD_SEL_DST 2'h1
`define SXD_SEL_CNT 2'h2
`define SXD_SEL_CTL 2'h3

/*****************************************************************
 * control register fields
 *****************************************************************/
`define SXD_CTL_EN 0
`define SXD_CTL_PRIO_HI 2
`define SXD_CTL_PRIO_LO 1
`define SXD_CTL_TRIG_HI 6
`define SXD_CTL_TRIG_LO 3
`define SXD_CTL_CMODE_HI 9
`define SXD_CTL_CMODE_LO 7
`define SXD_CTL_SAM_HI 11
`define SXD_CTL_SAM_LO 10
`define SXD_CTL_DAM_HI 13
`define SXD_CTL_DAM_LO 12
`define SXD_CTL_SOFS_HI 15
`define SXD_CTL_SOFS_LO 14
`define SXD_CTL_DOFS_HI 17
`define SXD_CTL_DOFS_LO 16
`define SXD_CTL_SEXT 18
`define SXD_CTL_DEXT 19

/*****************************************************************
 * trigger codes
 *****************************************************************/
`define SXD_TRIG_SW 4'h0
`define SXD_TRIG_PIN_FIRST 4'h1
`define SXD_TRIG_PIN_LAST 4'h8
`define SXD_TRIG_CH_FIRST 4'h9
`define SXD_TRIG_CH_LAST 4'hE

/*****************************************************************
 * counter field masks, low field first
 *****************************************************************/
`define SXD_CM0_X 24'hFFFFFF
`define SXD_CM0_Y 24'h000000
`define SXD_CM1_X 24'h000FFF
`define SXD_CM1_Y 24'hFFF000
`define SXD_CM2_X 24'h00003F
`define SXD_CM2_Y 24'h000FC0
`define SXD_CM3_X 24'h000FFF
`define SXD_CM3_Y 24'h03F000
`define SXD_CM4_X 24'h00003F
`define SXD_CM4_Y 24'h03FFC0

/*****************************************************************
 * reset values and timing
 *****************************************************************/
`define SXD_REG_RESET 24'h000000
`define SXD_MIN_WORD_CYC 2

`endif

// >>> sxd_pkg.sv
/*
 * Types shared by the transfer engine modules: sequencer states, address
 * modes and the packed state records.
 * Assumes sxd_defines.svh on the include path.
 */
`include "sxd_defines.svh"

package sxd_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} sxd_state_e;

	typedef enum logic [1:0] {
		AM_CONST = 2'h0,
		AM_LIN   = 2'h1,
		AM_2D    = 2'h2,
		AM_3D    = 2'h3
	} sxd_amode_e;

	typedef struct packed {
		logic [`SXD_W-1:0] src;
		logic [`SXD_W-1:0] dst;
		logic [`SXD_W-1:0] cnt;
		logic [`SXD_W-1:0] ctl;
		logic [`SXD_W-1:0] rld;
		logic pend;
		logic done;
	} sxd_chan_s;

	typedef struct packed {
		sxd_state_e st;
		logic [2:0] ch;
		logic [`SXD_W-1:0] addr;
		logic ext;
		logic rd;
		logic wr;
		logic [`SXD_W-1:0] wdata;
		logic [`SXD_NUM_OFS-1:0][`SXD_W-1:0] offs;
		logic [`SXD_W-1:0] rdata;
	} sxd_top_s;

endpackage

// >>> sxd_chan_if.sv
/*
 * Link between the sequencer and one channel.
 * Assumes one instance per channel, driven by the top module.
 */
`timescale 1ns/100ps

interface sxd_chan_if;
	logic wr;
	logic [1:0] wsel;
	logic [23:0] wdata;
	logic step;
	logic trig;
	logic [3:0][23:0] offs;
	logic [23:0] src;
	logic [23:0] dst;
	logic [23:0] cnt;
	logic [23:0] ctl;
	logic req;
	logic done;

	modport ctrl (output wr, wsel, wdata, step, trig, offs, input src, dst, cnt, ctl, req, done);
	modport chan (input wr, wsel, wdata, step, trig, offs, output src, dst, cnt, ctl, req, done);
endinterface

// >>> sxd_chan.sv
/*
 * One channel: pointers, counter, control, trigger latch and address stepping.
 * Assumes step comes only while this channel owns the bus and word completes.
 */
`timescale 1ns/100ps

module sxd_chan
	import sxd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// sequencer side
	sxd_chan_if.chan cif
);
	sxd_chan_s s_reg;
	sxd_chan_s s_next;
	logic [23:0] xmask;
	logic [23:0] ymask;
	logic [23:0] ylsb;
	logic [23:0] zlsb;
	logic line_end;
	logic table_end;
	logic blk_end;

	function automatic logic [23:0] next_ptr(input logic [23:0] p, input logic [1:0] am,
			input logic [23:0] oa, input logic [23:0] ob, input logic le, input logic te);
		logic [23:0] r;
		r = p;
		unique case (sxd_amode_e'(am))
			AM_CONST: r = p;
			AM_LIN: r = p + 24'h000001;
			AM_2D: r = le ? p + oa : p + 24'h000001;
			AM_3D: r = te ? p + ob : (le ? p + oa : p + 24'h000001);
		endcase
		return r;
	endfunction

	/*****************************************************************
	 * counter field layout
	 *****************************************************************/
	always_comb begin
		unique case (s_reg.ctl[`SXD_CTL_CMODE_HI:`SXD_CTL_CMODE_LO])
			3'h1: begin
				xmask = `SXD_CM1_X;
				ymask = `SXD_CM1_Y;
			end
			3'h2: begin
				xmask = `SXD_CM2_X;
				ymask = `SXD_CM2_Y;
			end
			3'h3: begin
				xmask = `SXD_CM3_X;
				ymask = `SXD_CM3_Y;
			end
			3'h4: begin
				xmask = `SXD_CM4_X;
				ymask = `SXD_CM4_Y;
			end
			default: begin
				xmask = `SXD_CM0_X;
				ymask = `SXD_CM0_Y;
			end
		endcase
		ylsb = ymask & (~ymask + 24'h000001);
		zlsb = (xmask | ymask) + 24'h000001;
		line_end = (s_reg.cnt & xmask) == 24'h000000;
		table_end = line_end && ((s_reg.cnt & ymask) == 24'h000000);
		blk_end = s_reg.cnt == 24'h000000;
	end

	/*****************************************************************
	 * next state
	 *****************************************************************/
	always_comb begin
		logic [23:0] s_oa;
		logic [23:0] s_ob;
		logic [23:0] d_oa;
		logic [23:0] d_ob;
		logic [1:0] so;
		logic [1:0] dof;
		so = s_reg.ctl[`SXD_CTL_SOFS_HI:`SXD_CTL_SOFS_LO];
		dof = s_reg.ctl[`SXD_CTL_DOFS_HI:`SXD_CTL_DOFS_LO];
		s_oa = cif.offs[so];
		s_ob = cif.offs[2'(so + 2'h1)];
		d_oa = cif.offs[dof];
		d_ob = cif.offs[2'(dof + 2'h1)];
		s_next = s_reg;
		s_next.done = 1'b0;
		if (cif.step) begin
			s_next.src = next_ptr(s_reg.src, s_reg.ctl[`SXD_CTL_SAM_HI:`SXD_CTL_SAM_LO],
				s_oa, s_ob, line_end, table_end);
			s_next.dst = next_ptr(s_reg.dst, s_reg.ctl[`SXD_CTL_DAM_HI:`SXD_CTL_DAM_LO],
				d_oa, d_ob, line_end, table_end);
			// the live counter itself steps; rld only restores fields
			if (blk_end) begin
				s_next.cnt = s_reg.rld;
				s_next.ctl[`SXD_CTL_EN] = 1'b0;
				s_next.done = 1'b1;
			end else if (!line_end) begin
				s_next.cnt = s_reg.cnt - 24'h000001;
			end else if (!table_end) begin
				s_next.cnt = (s_reg.cnt - ylsb) | (s_reg.rld & xmask);
			end else begin
				s_next.cnt = (s_reg.cnt - zlsb) | (s_reg.rld & (xmask | ymask));
			end
			s_next.pend = 1'b0;
		end
		// a trigger in the consuming cycle is kept
		if (cif.trig && s_reg.ctl[`SXD_CTL_EN]) begin
			s_next.pend = 1'b1;
		end
		if (cif.wr) begin
			unique case (cif.wsel)
				`SXD_SEL_SRC: s_next.src = cif.wdata;
				`SXD_SEL_DST: s_next.dst = cif.wdata;
				`SXD_SEL_CNT: begin
					s_next.cnt = cif.wdata;
					s_next.rld = cif.wdata;
				end
				`SXD_SEL_CTL: begin
					s_next.ctl = cif.wdata;
					s_next.pend = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cif.src = s_reg.src;
	assign cif.dst = s_reg.dst;
	assign cif.cnt = s_reg.cnt;
	assign cif.ctl = s_reg.ctl;
	assign cif.done = s_reg.done;
	assign cif.req = s_reg.ctl[`SXD_CTL_EN] && ((s_reg.ctl[`SXD_CTL_TRIG_HI:`SXD_CTL_TRIG_LO]
		== `SXD_TRIG_SW) || s_reg.pend);

	/*****************************************************************
	 * checks
	 *****************************************************************/
	a_block_end_stop: assert property (@(posedge clk) disable iff (!reset_n)
		(cif.step && blk_end && !cif.wr) |=> (!s_reg.ctl[`SXD_CTL_EN] && s_reg.done
		&& s_reg.cnt == s_reg.rld))
		else $error("block end did not stop channel");
	a_count_down: assert property (@(posedge clk) disable iff (!reset_n)
		(cif.step && !line_end && !cif.wr) |=> s_reg.cnt == $past(s_reg.cnt) - 24'h000001)
		else $error("counter low field did not decrement");
endmodule

// >>> sxd_arb.sv
/*
 * Channel arbiter: highest priority requester wins, lower index on a tie.
 * Assumes requests and priorities come straight from the channels.
 */
`timescale 1ns/100ps

module sxd_arb
	import sxd_pkg::*;
(
	// clock and reset, for checks only
	input wire logic clk,
	input wire logic reset_n,
	// requests
	input wire logic [5:0] req,
	input wire logic [5:0][1:0] prio,
	// grant
	output logic valid,
	output logic [2:0] idx
);
	always_comb begin
		logic [1:0] best;
		best = 2'h0;
		valid = 1'b0;
		idx = 3'h0;
		for (int i = 0; i < `SXD_NUM_CH; i++) begin
			if (req[i] && (!valid || prio[i] > best)) begin
				valid = 1'b1;
				best = prio[i];
				idx = 3'(i);
			end
		end
	end

	a_grant_request: assert property (@(posedge clk) disable iff (!reset_n)
		valid == (req != 6'h00) && (!valid || req[idx]))
		else $error("grant without matching request");
endmodule

// >>> sxd_top.sv
/*
 * Six-channel transfer engine: register port, trigger routing, arbitration
 * and the read-then-write word sequencer on the engine's own bus.
 * Assumes internal accesses finish in their cycle unless the core holds the
 * same partition, and external accesses finish when ext_ready is high.
 */
`timescale 1ns/100ps


module sxd_top
	import sxd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	// trigger sources
	input wire logic [7:0] trig_in,
	// transfer bus
	output logic [23:0] dma_addr,
	output logic dma_ext,
	output logic dma_rd,
	output logic dma_wr,
	output logic [23:0] dma_wdata,
	input wire logic [23:0] dma_rdata,
	input wire logic ext_ready,
	input wire logic core_conflict
);
	sxd_top_s s_reg;
	sxd_top_s s_next;
	logic [5:0][23:0] ch_src;
	logic [5:0][23:0] ch_dst;
	logic [5:0][23:0] ch_cnt;
	logic [5:0][23:0] ch_ctl;
	logic [5:0][1:0] ch_prio;
	logic [5:0] ch_req;
	logic [5:0] ch_done;
	logic [5:0] ch_en;
	logic [5:0] step_v;
	logic gnt_valid;
	logic [2:0] gnt_idx;
	logic acc_done;
	logic ch_space;
	logic [23:0] status;

	/*****************************************************************
	 * channels
	 *****************************************************************/
	sxd_chan_if cif [`SXD_NUM_CH] ();

	assign ch_space = reg_addr <= `SXD_IDX_CH_LAST;

	genvar g;
	generate
		for (g = 0; g < `SXD_NUM_CH; g++) begin : gen_ch
			logic [3:0] tcode;
			assign tcode = ch_ctl[g][`SXD_CTL_TRIG_HI:`SXD_CTL_TRIG_LO];
			assign cif[g].wr = reg_wr && ch_space && (reg_addr[4:2] == 3'(g));
			assign cif[g].wsel = reg_addr[1:0];
			assign cif[g].wdata = reg_wdata;
			assign cif[g].step = step_v[g];
			assign cif[g].offs = s_reg.offs;
			// at most one source feeds the latch, picked by the code; software and unused codes feed none
			assign cif[g].trig = (tcode >= `SXD_TRIG_PIN_FIRST && tcode <= `SXD_TRIG_PIN_LAST)
				? trig_in[3'(tcode - `SXD_TRIG_PIN_FIRST)]
				: ((tcode >= `SXD_TRIG_CH_FIRST && tcode <= `SXD_TRIG_CH_LAST)
				? ch_done[3'(tcode - `SXD_TRIG_CH_FIRST)] : 1'b0);
			assign ch_src[g] = cif[g].src;
			assign ch_dst[g] = cif[g].dst;
			assign ch_cnt[g] = cif[g].cnt;
			assign ch_ctl[g] = cif[g].ctl;
			assign ch_req[g] = cif[g].req;
			assign ch_done[g] = cif[g].done;
			assign ch_en[g] = cif[g].ctl[`SXD_CTL_EN];
			assign ch_prio[g] = cif[g].ctl[`SXD_CTL_PRIO_HI:`SXD_CTL_PRIO_LO];
			assign step_v[g] = (s_reg.st == ST_WRITE) && acc_done && (s_reg.ch == 3'(g));

			sxd_chan u_chan (
				.clk(clk),
				.reset_n(reset_n),
				.cif(cif[g])
			);
		end
	endgenerate

	/*****************************************************************
	 * arbitration
	 *****************************************************************/
	sxd_arb u_arb (
		.clk(clk),
		.reset_n(reset_n),
		.req(ch_req),
		.prio(ch_prio),
		.valid(gnt_valid),
		.idx(gnt_idx)
	);

	/*****************************************************************
	 * access completion
	 *****************************************************************/
	// external side waits for the bus interface; internal side yields to
	// the core only when both hit the same partition
	assign acc_done = s_reg.ext ? ext_ready : !core_conflict;

	assign status = {8'h00, s_reg.st != ST_IDLE, s_reg.ch, ch_req, ch_en};

	/*****************************************************************
	 * next state
	 *****************************************************************/
	always_comb begin
		s_next = s_reg;
		unique case (s_reg.st)
			ST_IDLE: begin
				if (gnt_valid) begin
					s_next.st = ST_READ;
					s_next.ch = gnt_idx;
					s_next.addr = ch_src[gnt_idx];
					s_next.ext = ch_ctl[gnt_idx][`SXD_CTL_SEXT];
					s_next.rd = 1'b1;
				end
			end
			ST_READ: begin
				if (acc_done) begin
					s_next.st = ST_WRITE;
					s_next.rd = 1'b0;
					s_next.wr = 1'b1;
					s_next.addr = ch_dst[s_reg.ch];
					s_next.ext = ch_ctl[s_reg.ch][`SXD_CTL_DEXT];
					s_next.wdata = dma_rdata;
				end
			end
			ST_WRITE: begin
				// the next channel waits until this write lands
				if (acc_done) begin
					s_next.st = ST_IDLE;
					s_next.wr = 1'b0;
				end
			end
		endcase
		if (reg_wr && reg_addr >= `SXD_IDX_OFS_BASE && reg_addr <= `SXD_IDX_OFS_LAST) begin
			s_next.offs[2'(reg_addr - `SXD_IDX_OFS_BASE)] = reg_wdata;
		end
		if (reg_rd) begin
			if (ch_space) begin
				unique case (reg_addr[1:0])
					`SXD_SEL_SRC: s_next.rdata = ch_src[reg_addr[4:2]];
					`SXD_SEL_DST: s_next.rdata = ch_dst[reg_addr[4:2]];
					`SXD_SEL_CNT: s_next.rdata = ch_cnt[reg_addr[4:2]];
					`SXD_SEL_CTL: s_next.rdata = ch_ctl[reg_addr[4:2]];
				endcase
			end else if (reg_addr <= `SXD_IDX_OFS_LAST) begin
				s_next.rdata = s_reg.offs[2'(reg_addr - `SXD_IDX_OFS_BASE)];
			end else if (reg_addr == `SXD_IDX_STATUS) begin
				s_next.rdata = status;
			end else begin
				s_next.rdata = `SXD_REG_RESET;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	/*****************************************************************
	 * outputs
	 *****************************************************************/
	assign reg_rdata = s_reg.rdata;
	assign dma_addr = s_reg.addr;
	assign dma_ext = s_reg.ext;
	assign dma_rd = s_reg.rd;
	assign dma_wr = s_reg.wr;
	assign dma_wdata = s_reg.wdata;

	/*****************************************************************
	 * checks
	 *****************************************************************/
	a_state_one_hot: assert property (@(posedge clk) disable iff (!reset_n)
		$onehot(s_reg.st) && !(dma_rd && dma_wr) && $onehot0(step_v))
		else $error("sequencer state or strobes overlap");

	a_read_source: assert property (@(posedge clk) disable iff (!reset_n)
		(s_reg.st == ST_IDLE && gnt_valid) |=> (dma_rd && !dma_wr
		&& dma_addr == $past(ch_src[gnt_idx]) && s_reg.ch == $past(gnt_idx)))
		else $error("read did not start at source pointer");

	a_write_dest: assert property (@(posedge clk) disable iff (!reset_n)
		(s_reg.st == ST_READ && acc_done) |=> (dma_wr && !dma_rd
		&& dma_addr == $past(ch_dst[s_reg.ch]) && dma_wdata == $past(dma_rdata)))
		else $error("write did not go to destination pointer");

	a_internal_two: assert property (@(posedge clk) disable iff (!reset_n)
		(s_reg.st == ST_READ && !dma_ext && !core_conflict)
		##1 (!dma_ext && !core_conflict) |=> (s_reg.st == ST_IDLE && !dma_wr))
		else $error("internal word did not finish in two cycles");

	a_ext_wait: assert property (@(posedge clk) disable iff (!reset_n)
		(s_reg.st != ST_IDLE && dma_ext && !ext_ready) |=> ($stable(s_reg.st)
		&& $stable(dma_addr)))
		else $error("external access moved on without ready");

	a_core_first: assert property (@(posedge clk) disable iff (!reset_n)
		(s_reg.st == ST_READ && !dma_ext && core_conflict) |=> (s_reg.st == ST_READ && dma_rd))
		else $error("engine did not yield the partition to the core");

	a_owner_stable: assert property (@(posedge clk) disable iff (!reset_n)
		(s_reg.st != ST_IDLE && $past(s_reg.st) != ST_IDLE) |-> $stable(s_reg.ch))
		else $error("bus owner changed inside a word");

	a_step_on_write: assert property (@(posedge clk) disable iff (!reset_n)
		(step_v != 6'h00) |-> (s_reg.st == ST_WRITE && acc_done
		&& step_v[s_reg.ch]))
		else $error("channel stepped outside its write");

	a_step_counts: assert property (@(posedge clk) disable iff (!reset_n)
		(step_v != 6'h00 && !reg_wr) |=> (($past(ch_cnt[s_reg.ch]) == 24'h000000)
		? !ch_en[s_reg.ch] : (ch_cnt[s_reg.ch] != $past(ch_cnt[s_reg.ch]))))
		else $error("stepped counter neither counted nor ended the block");

	a_status_view: assert property (@(posedge clk) disable iff (!reset_n)
		(reg_rd && reg_addr == `SXD_IDX_STATUS) |=> (reg_rdata[5:0] == $past(ch_en)
		&& reg_rdata[11:6] == $past(ch_req) && reg_rdata[23:16] == 8'h00))
		else $error("status read does not match channel state");
endmodule

// >>> sxd_mem_model.sv
/*
 * Far-side model of the transfer bus: memory and I/O space with external
 * wait states and core partition clashes, logging every completed access.
 * Assumes the bench drives core_conflict and wait_n off the rising edge.
 */
`timescale 1ns/100ps

module sxd_mem_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// transfer bus
	input wire logic [23:0] dma_addr,
	input wire logic dma_ext,
	input wire logic dma_rd,
	input wire logic dma_wr,
	input wire logic [23:0] dma_wdata,
	output logic [23:0] dma_rdata,
	output logic ext_ready,
	input wire logic core_conflict,
	// wait states per external access
	input wire logic [1:0] wait_n
);
	logic [23:0] mem [int];
	logic [23:0] rd_q[$];
	logic [23:0] wr_q[$];
	logic [23:0] wd_q[$];
	int len_q[$];
	int wcnt = 0;
	int plen = 0;
	int overlap = 0;
	logic [23:0] last = 24'h000000;
	logic act;
	logic fin;

	function automatic logic [23:0] init_val(logic [23:0] a);
		return a ^ 24'hA5C3F0;
	endfunction

	// stored word, or the fill pattern where nothing was written yet
	function automatic logic [23:0] peek(logic [23:0] a);
		return mem.exists(a) ? mem[a] : init_val(a);
	endfunction

	/*****************************************************************
	 * access completion
	 *****************************************************************/
	assign act = dma_rd | dma_wr;
	assign ext_ready = act && dma_ext && wcnt == int'(wait_n);
	// core owns a clashing partition, external space is never stalled by it
	assign fin = act && (dma_ext ? ext_ready : !core_conflict);
	// a released data line shows the inverse of the last word
	assign dma_rdata = dma_rd ? peek(dma_addr) : ~last;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wcnt <= 0;
			plen <= 0;
		end else if (fin) begin
			len_q.push_back(plen + 1);
			wcnt <= 0;
			plen <= 0;
			if (dma_rd) begin
				rd_q.push_back(dma_addr);
				last <= dma_rdata;
			end else begin
				wr_q.push_back(dma_addr);
				wd_q.push_back(dma_wdata);
				mem[dma_addr] = dma_wdata;
			end
		end else if (act) begin
			plen <= plen + 1;
			wcnt <= dma_ext ? wcnt + 1 : 0;
		end
		if (dma_rd && dma_wr)
			overlap <= overlap + 1;
	end
endmodule

// >>> tb_top.sv
/*
 * Self-checking bench of the six-channel transfer engine.
 * Assumes sxd_top and sxd_mem_model are compiled before it.
 */
`timescale 1ns/100ps

module tb_top;
	logic clk, reset_n, reg_wr, reg_rd, core_conflict, dma_ext, dma_rd, dma_wr, ext_ready;
	logic [4:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata, dma_addr, dma_wdata, dma_rdata, s, d, c, ctl, es, ed;
	logic [7:0] trig_in;
	logic [1:0] wait_n;
	logic conf_en = 1'b0;
	logic [31:0] seed = 32'h000075F4;
	int n_mismatch = 0;
	int n_compared = 0;
	int XW[5] = '{24, 12, 6, 12, 6};
	int YW[5] = '{0, 12, 6, 6, 12};
	logic [23:0] ofs[4];
	logic [23:0] rexp[32];
	logic [23:0] ers[$];
	logic [23:0] ews[$];

	sxd_top i_sxd_top (.clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.trig_in, .dma_addr, .dma_ext, .dma_rd, .dma_wr, .dma_wdata, .dma_rdata,
		.ext_ready, .core_conflict);
	sxd_mem_model i_mem (.clk, .reset_n, .dma_addr, .dma_ext, .dma_rd, .dma_wr,
		.dma_wdata, .dma_rdata, .ext_ready, .core_conflict, .wait_n);

	/*****************************************************************
	 * helpers
	 *****************************************************************/
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(int a, logic [23:0] v);
		@(negedge clk) reg_addr = a[4:0];
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk) reg_wr = 1'b0;
	endtask

	task automatic rd(int a, output logic [23:0] v);
		@(negedge clk) reg_addr = a[4:0];
		reg_rd = 1'b1;
		@(negedge clk) reg_rd = 1'b0;
		v = reg_rdata;
	endtask

	task automatic pulse(int p);
		@(negedge clk) trig_in = 8'h01 << p;
		@(negedge clk) trig_in = 8'h00;
		repeat (10) @(negedge clk);
	endtask

	function automatic logic [23:0] stp(int am, int sel, int x, int y);
		if (am == 0)
			return 24'h000000;
		if (am == 1 || x != 0)
			return 24'h000001;
		if (am == 3 && y == 0)
			return ofs[(sel + 1) % 4];
		return ofs[sel];
	endfunction

	// reference walk of one block: addresses per word and final pointers
	task automatic predict(int m, int sam, int dam, int ss, int ds);
		int x0, y0, x, y, z;
		x0 = c & ((1 << XW[m]) - 1);
		y0 = (c >> XW[m]) & ((1 << YW[m]) - 1);
		z = c >> (XW[m] + YW[m]);
		x = x0;
		y = y0;
		es = s;
		ed = d;
		ers.delete();
		ews.delete();
		forever begin
			ers.push_back(es);
			ews.push_back(ed);
			es = es + stp(sam, ss, x, y);
			ed = ed + stp(dam, ds, x, y);
			if (x == 0 && y == 0 && z == 0)
				break;
			if (x != 0)
				x--;
			else if (y != 0) begin
				y--;
				x = x0;
			end else begin
				z--;
				x = x0;
				y = y0;
			end
		end
	endtask

	/*****************************************************************
	 * clock, stall noise, watchdog
	 *****************************************************************/
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(negedge clk) begin
		logic [31:0] r;
		r = xs();
		core_conflict <= conf_en & r[0];
	end

	initial begin
		#250000;
		n_mismatch++;
		test_done();
	end

	/*****************************************************************
	 * scenarios
	 *****************************************************************/
	initial begin
		logic [23:0] v;
		int sam, dam, ss, ds, k;
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 24'h000000;
		trig_in = 8'h00;
		wait_n = 2'h0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		// reset values, read/write access, read-only and unmapped places
		for (int a = 0; a < 32; a++) begin
			rd(a, v);
			chk("reset value", v, 24'h000000);
			rexp[a] = (a < 28) ? (xs() & ((a % 4 == 3 && a < 24) ? 32'hFFFFFE : 32'hFFFFFF)) : 0;
			wr(a, (a < 28) ? rexp[a] : xs());
		end
		for (int a = 0; a < 32; a++) begin
			rd(a, v);
			chk("register readback", v, rexp[a]);
		end
		// one software-triggered block per counter mode, mixed dimensions
		for (int m = 0; m < 5; m++) begin
			for (int i = 0; i < 4; i++) begin
				ofs[i] = xs() & 32'h3F;
				wr(24 + i, ofs[i]);
			end
			s = 24'h100000 + (m << 12);
			d = 24'h800000 + (m << 12);
			c = (xs() % 3) | ((xs() % 3) << XW[m]) | ((xs() % 3) << (XW[m] + YW[m]));
			sam = m % 4;
			dam = (m + 1) % 4;
			ss = xs() % 4;
			ds = xs() % 4;
			wait_n = xs();
			conf_en = (m == 4);
			ctl = 1 | ((xs() % 4) << 1) | (m << 7) | (sam << 10) | (dam << 12) | (ss << 14)
				| (ds << 16) | ((m & 1) << 18) | (((m >> 1) & 1) << 19);
			wr(4 * m, s);
			wr(4 * m + 1, d);
			wr(4 * m + 2, c);
			predict(m, sam, dam, ss, ds);
			i_mem.rd_q.delete();
			i_mem.wr_q.delete();
			i_mem.wd_q.delete();
			i_mem.len_q.delete();
			wr(4 * m + 3, ctl);
			k = 0;
			do begin
				rd(28, v);
				k++;
			end while ((v[m] !== 1'b0 || v[15] !== 1'b0) && k < 500);
			chk("block finished", k < 500, 1'b1);
			chk("word count", i_mem.wr_q.size(), ers.size());
			foreach (ers[i]) begin
				chk("read address", i_mem.rd_q[i], ers[i]);
				chk("write address", i_mem.wr_q[i], ews[i]);
				chk("word data", i_mem.wd_q[i], i_mem.init_val(ers[i]));
			end
			if (!conf_en)
				foreach (i_mem.len_q[i])
					chk("phase cycles", i_mem.len_q[i], ctl[18 + i % 2] ? wait_n + 1 : 1);
			rd(4 * m, v);
			chk("source pointer", v, es);
			rd(4 * m + 1, v);
			chk("destination pointer", v, ed);
			rd(4 * m + 2, v);
			chk("counter", v, c);
			rd(4 * m + 3, v);
			chk("control", v, ctl & 24'hFFFFFE);
			rd(28, v);
			chk("status idle", v, 24'(m << 12));
		end
		conf_en = 1'b0;
		// channel 5: one word per pulse of its own pin, none for another pin
		wr(20, 24'h300000);
		wr(21, 24'h900000);
		wr(22, 24'h000040);
		for (int t = 1; t < 9; t++) begin
			wr(23, 1 | (t << 3) | (1 << 10) | (1 << 12));
			i_mem.rd_q.delete();
			pulse(t % 8);
			chk("foreign trigger", i_mem.rd_q.size(), 0);
			pulse(t - 1);
			chk("triggered words", i_mem.rd_q.size(), 1);
			chk("triggered source", i_mem.rd_q[0], 24'h300000 + t - 1);
		end
		// pin 0 wakes channels 2 and 3, channel 3 wins on priority;
		// the end of channel 2's one-word block wakes channel 1
		for (int n = 1; n < 4; n++) begin
			wr(4 * n, 24'h400000 + n);
			wr(4 * n + 2, 24'h000000);
		end
		wr(7, 1 | (11 << 3));
		wr(11, 1 | (1 << 3));
		wr(15, 1 | (3 << 1) | (1 << 3));
		i_mem.rd_q.delete();
		pulse(0);
		chk("priority first", i_mem.rd_q[0], 24'h400003);
		chk("priority second", i_mem.rd_q[1], 24'h400002);
		chk("chained trigger", i_mem.rd_q[2], 24'h400001);
		chk("bus overlap", i_mem.overlap, 0);
		test_done();
	end
endmodule
